// *** ebt_timer.sv ***
// eight-bit timer/counter with one compare channel, pwm modes and apb registers
`timescale 1ns/10ps

module ebt_timer
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous timer oscillator input, sampled on pclk
    input wire logic async_osc_in,
    // interrupt vector acknowledge pulses
    input wire logic ack_overflow,
    input wire logic ack_compare,
    // compare output pin and interrupt
    output logic compare_output_pin,
    output logic compare_output_oe,
    output logic compare_pin_override,
    output logic irq
);

    // ========================================================
    // state
    typedef struct packed
    {
        logic [6:0] ctrl;
        logic [7:0] count;
        logic [7:0] ocr_buf;
        logic [7:0] ocr;
        logic down;
        logic block;
        logic wave;
        logic [1:0] status;
        logic [1:0] mask;
        logic async_sel;
        logic pin_dir;
        logic [EBT_PRESC_W-1:0] presc;
        logic osc_prev;
        logic [31:0] rdata;
        logic err;
    } ebt_state_t;
    ebt_state_t st;
    ebt_state_t next_st;
    logic setup_ph, wr_en, addr_ok, src_tick, timer_tick;
    logic [EBT_NUM_TAPS-1:0] tap_tick;
    ebt_mode_t mode;
    ebt_com_t com;

    // ========================================================
    // bus phase decode; zero wait states keep the master simple
    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = st.rdata;
    assign pslverr = st.err;
    // address decode for the error answer; read capture decodes paddr on its own
    always_comb
    begin
        case (paddr)
            EBT_ADDR_CTRL, EBT_ADDR_COUNT, EBT_ADDR_COMPARE,
            EBT_ADDR_STATUS, EBT_ADDR_MASK, EBT_ADDR_AUX: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    // current mode and output action
    assign mode = ebt_mode_t'({st.ctrl[EBT_CTRL_WGM1], st.ctrl[EBT_CTRL_WGM0]});
    assign com = ebt_com_t'(st.ctrl[EBT_CTRL_COM_HI:EBT_CTRL_COM_LO]);

    // ========================================================
    // source clock: every pclk, or each rising edge of the oscillator input
    assign src_tick = st.async_sel ? (async_osc_in && !st.osc_prev) : 1'b1;
    // divided taps; a tap fires when its low prescaler bits are all ones
    genvar gi;
    generate
        for (gi = 0; gi < EBT_NUM_TAPS; gi = gi + 1)
        begin : g_tap
            assign tap_tick[gi] = src_tick && (&st.presc[EBT_TAP_LOG2[gi]-1:0]);
        end
    endgenerate
    // clock select multiplexer
    always_comb
    begin
        case (st.ctrl[EBT_CTRL_CS_HI:0])
            3'h0: timer_tick = 1'b0;
            3'h1: timer_tick = src_tick;
            3'h2: timer_tick = tap_tick[0];
            3'h3: timer_tick = tap_tick[1];
            3'h4: timer_tick = tap_tick[2];
            3'h5: timer_tick = tap_tick[3];
            3'h6: timer_tick = tap_tick[4];
            3'h7: timer_tick = tap_tick[5];
            default: timer_tick = 1'b0;
        endcase
    end

    // ========================================================
    // next state
    always_comb
    begin
        logic [7:0] top;
        logic at_top, match, special, ovf_ev, cmp_ev, force_ev;
        ebt_mode_t wmode;
        ebt_com_t wcom;
        top = EBT_MAX;
        at_top = 1'b0;
        match = 1'b0;
        special = 1'b0;
        ovf_ev = 1'b0;
        cmp_ev = 1'b0;
        force_ev = 1'b0;
        wmode = ebt_mode_t'({pwdata[EBT_CTRL_WGM1], pwdata[EBT_CTRL_WGM0]});
        wcom = ebt_com_t'(pwdata[EBT_CTRL_COM_HI:EBT_CTRL_COM_LO]);
        next_st = st;
        next_st.osc_prev = async_osc_in;
        // prescaler advances on source ticks; reset strobe wins
        if (src_tick)
        begin
            next_st.presc = st.presc + 1'b1;
        end
        if (wr_en && paddr == EBT_ADDR_AUX && pwdata[EBT_AUX_PRESC_RST])
        begin
            next_st.presc = '0;
        end
        // top value and compare event for this timer clock
        if (mode == EBT_MODE_CLEAR_ON_MATCH)
        begin
            top = st.ocr;
        end
        at_top = (st.count == top);
        match = timer_tick && !st.block && (st.count == st.ocr);
        special = (st.ocr == EBT_MAX) && com[1] &&
                  (mode == EBT_MODE_FAST_PWM || mode == EBT_MODE_PHASE_PWM);
        // ------------------------------------------------
        // counting sequence and overflow events
        if (timer_tick)
        begin
            next_st.block = 1'b0;
            case (mode)
                EBT_MODE_PHASE_PWM:
                begin
                    if (!st.down)
                    begin
                        if (st.count == EBT_MAX)
                        begin
                            next_st.down = 1'b1;
                            next_st.count = st.count - 1'b1;
                            next_st.ocr = st.ocr_buf;
                        end
                        else
                        begin
                            next_st.count = st.count + 1'b1;
                        end
                    end
                    else
                    begin
                        if (st.count == EBT_BOTTOM)
                        begin
                            next_st.down = 1'b0;
                            next_st.count = st.count + 1'b1;
                            ovf_ev = 1'b1;
                        end
                        else
                        begin
                            next_st.count = st.count - 1'b1;
                        end
                    end
                end
                EBT_MODE_CLEAR_ON_MATCH:
                begin
                    ovf_ev = (st.count == EBT_MAX);
                    // a match at top clears the counter; forced matches never do
                    if (at_top && !st.block)
                    begin
                        next_st.count = EBT_BOTTOM;
                    end
                    else
                    begin
                        next_st.count = st.count + 1'b1;
                    end
                end
                EBT_MODE_FAST_PWM:
                begin
                    ovf_ev = (st.count == EBT_MAX);
                    next_st.count = st.count + 1'b1;
                    if (st.count == EBT_MAX)
                    begin
                        next_st.ocr = st.ocr_buf;
                    end
                end
                default:
                begin
                    ovf_ev = (st.count == EBT_MAX);
                    next_st.count = st.count + 1'b1;
                end
            endcase
        end
        // ------------------------------------------------
        // waveform unit
        case (mode)
            EBT_MODE_FAST_PWM:
            begin
                if (match && !special)
                begin
                    if (com == EBT_COM_CLEAR)
                    begin
                        next_st.wave = 1'b0;
                    end
                    else if (com == EBT_COM_SET)
                    begin
                        next_st.wave = 1'b1;
                    end
                end
                else if (timer_tick && st.count == EBT_MAX && !special)
                begin
                    // the wrap to bottom restores the idle level
                    if (com == EBT_COM_CLEAR)
                    begin
                        next_st.wave = 1'b1;
                    end
                    else if (com == EBT_COM_SET)
                    begin
                        next_st.wave = 1'b0;
                    end
                end
                else if (timer_tick && st.count == EBT_MAX && special)
                begin
                    // compare at top: match ignored, level set at top
                    next_st.wave = (com == EBT_COM_CLEAR);
                end
            end
            EBT_MODE_PHASE_PWM:
            begin
                if (timer_tick && special && st.count == EBT_MAX)
                begin
                    // take the up-counting result so the pulse stays symmetric
                    next_st.wave = (com == EBT_COM_SET);
                end
                else if (match && !special)
                begin
                    if (com == EBT_COM_CLEAR)
                    begin
                        next_st.wave = st.down;
                    end
                    else if (com == EBT_COM_SET)
                    begin
                        next_st.wave = !st.down;
                    end
                end
            end
            default:
            begin
                if (match)
                begin
                    case (com)
                        EBT_COM_TOGGLE: next_st.wave = !st.wave;
                        EBT_COM_CLEAR: next_st.wave = 1'b0;
                        EBT_COM_SET: next_st.wave = 1'b1;
                        default: next_st.wave = st.wave;
                    endcase
                end
            end
        endcase
        cmp_ev = match;
        // ------------------------------------------------
        // register writes
        if (wr_en)
        begin
            case (paddr)
                EBT_ADDR_CTRL:
                begin
                    // force bit is a strobe and is never stored
                    next_st.ctrl = pwdata[6:0];
                    force_ev = pwdata[EBT_CTRL_FORCE] &&
                               (wmode == EBT_MODE_NORMAL ||
                                wmode == EBT_MODE_CLEAR_ON_MATCH);
                end
                EBT_ADDR_COUNT:
                begin
                    next_st.count = pwdata[7:0];
                    next_st.block = 1'b1;
                end
                EBT_ADDR_COMPARE:
                begin
                    next_st.ocr_buf = pwdata[7:0];
                    if (mode == EBT_MODE_NORMAL || mode == EBT_MODE_CLEAR_ON_MATCH)
                    begin
                        next_st.ocr = pwdata[7:0];
                    end
                end
                EBT_ADDR_MASK: next_st.mask = pwdata[1:0];
                EBT_ADDR_AUX:
                begin
                    next_st.async_sel = pwdata[EBT_AUX_ASYNC];
                    next_st.pin_dir = pwdata[EBT_AUX_PIN_DIR];
                end
                default: next_st.err = st.err;
            endcase
        end
        // forced match: output only, no flag, no counter clear
        if (force_ev)
        begin
            case (wcom)
                EBT_COM_TOGGLE: next_st.wave = !st.wave;
                EBT_COM_CLEAR: next_st.wave = 1'b0;
                EBT_COM_SET: next_st.wave = 1'b1;
                default: next_st.wave = st.wave;
            endcase
        end
        // ------------------------------------------------
        // sticky flags: write one or vector ack clears, a new event wins
        if (wr_en && paddr == EBT_ADDR_STATUS)
        begin
            next_st.status = st.status & ~pwdata[1:0];
        end
        // acks clear first, events set last so a coincident event is kept
        next_st.status = next_st.status & ~{ack_compare, ack_overflow};
        next_st.status = next_st.status | {cmp_ev, ovf_ev};
        // ------------------------------------------------
        // read data captured in the setup cycle, answered in access
        if (setup_ph)
        begin
            next_st.err = !addr_ok;
            next_st.rdata = 32'h0000_0000;
            if (!pwrite)
            begin
                case (paddr)
                    EBT_ADDR_CTRL: next_st.rdata = {24'h000000, 1'b0, st.ctrl};
                    EBT_ADDR_COUNT: next_st.rdata = {24'h000000, st.count};
                    EBT_ADDR_COMPARE: next_st.rdata = {24'h000000, st.ocr_buf};
                    EBT_ADDR_STATUS: next_st.rdata = {30'h00000000, st.status};
                    EBT_ADDR_MASK: next_st.rdata = {30'h00000000, st.mask};
                    EBT_ADDR_AUX: next_st.rdata = {29'h00000000, st.pin_dir, 1'b0,
                                                   st.async_sel};
                    default: next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.ctrl <= EBT_RST_CTRL[6:0];
            st.count <= EBT_RST_COUNT;
            st.ocr_buf <= EBT_RST_COMPARE;
            st.ocr <= EBT_RST_COMPARE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ========================================================
    // pin and interrupt outputs
    assign compare_pin_override = (com != EBT_COM_OFF);
    assign compare_output_oe = (com != EBT_COM_OFF) && st.pin_dir;
    assign compare_output_pin = st.wave;
    assign irq = |(st.status & st.mask);

endmodule

// *** ebt_pkg.sv ***
// constants, register map and types for the eight-bit compare/pwm timer
package ebt_pkg;

    // ========================================================
    // register byte addresses (apb, one aligned word each)
    localparam logic [7:0] EBT_ADDR_CTRL = 8'h00;
    localparam logic [7:0] EBT_ADDR_COUNT = 8'h04;
    localparam logic [7:0] EBT_ADDR_COMPARE = 8'h08;
    localparam logic [7:0] EBT_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] EBT_ADDR_MASK = 8'h10;
    localparam logic [7:0] EBT_ADDR_AUX = 8'h14;

    // ========================================================
    // timer_control_a field positions
    localparam int EBT_CTRL_FORCE = 7;
    localparam int EBT_CTRL_WGM1 = 6;
    localparam int EBT_CTRL_COM_HI = 5;
    localparam int EBT_CTRL_COM_LO = 4;
    localparam int EBT_CTRL_WGM0 = 3;
    localparam int EBT_CTRL_CS_HI = 2;

    // status / mask bit positions
    localparam int EBT_ST_OVF = 0;
    localparam int EBT_ST_CMP = 1;

    // aux register bit positions
    localparam int EBT_AUX_ASYNC = 0;
    localparam int EBT_AUX_PRESC_RST = 1;
    localparam int EBT_AUX_PIN_DIR = 2;

    // ========================================================
    // counter limits and reset values
    localparam logic [7:0] EBT_MAX = 8'hff;
    localparam logic [7:0] EBT_BOTTOM = 8'h00;
    localparam logic [7:0] EBT_RST_CTRL = 8'h00;
    localparam logic [7:0] EBT_RST_COUNT = 8'h00;
    localparam logic [7:0] EBT_RST_COMPARE = 8'h00;

    // prescaler: width and log2 of each divided tap (/8 ... /1024)
    localparam int EBT_PRESC_W = 10;
    localparam int EBT_NUM_TAPS = 6;
    localparam int EBT_TAP_LOG2 [EBT_NUM_TAPS] = '{3, 5, 6, 7, 8, 10};

    // ========================================================
    // waveform modes, code is {wgm1, wgm0}
    typedef enum logic [1:0]
    {
        EBT_MODE_NORMAL = 2'b00,
        EBT_MODE_PHASE_PWM = 2'b01,
        EBT_MODE_CLEAR_ON_MATCH = 2'b10,
        EBT_MODE_FAST_PWM = 2'b11
    } ebt_mode_t;

    // compare output actions
    typedef enum logic [1:0]
    {
        EBT_COM_OFF = 2'b00,
        EBT_COM_TOGGLE = 2'b01,
        EBT_COM_CLEAR = 2'b10,
        EBT_COM_SET = 2'b11
    } ebt_com_t;

endpackage

// *** ebt_timer_properties.sv ***
// port-level assertions for the eight-bit compare/pwm timer
`timescale 1ns/10ps

module ebt_timer_properties
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pin and interrupt
    input wire logic compare_output_pin,
    input wire logic compare_output_oe,
    input wire logic compare_pin_override,
    input wire logic irq
);
    // ========================================================
    // shadows of written bits, taken on the design's write edge
    logic [6:0] ctl;
    logic [1:0] msk;
    logic dir;
    logic wr;
    logic wr_ctl;
    logic quiet_force;
    assign wr = psel && penable && pready && pwrite;
    assign wr_ctl = wr && paddr == EBT_ADDR_CTRL;
    // stopped before and after: only the strobe can move the pin
    assign quiet_force = wr_ctl && pwdata[7] && pwdata[2:0] == 3'b000 && ctl[2:0] == 3'b000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl <= 7'h00;
            msk <= 2'b00;
            dir <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == EBT_ADDR_CTRL)
                ctl <= pwdata[6:0];
            if (paddr == EBT_ADDR_MASK)
                msk <= pwdata[1:0];
            if (paddr == EBT_ADDR_AUX)
                dir <= pwdata[EBT_AUX_PIN_DIR];
        end
    end

    default clocking dck @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ========================================================
    // register bus
    force_reads_zero_a: assert property (psel && penable && !pwrite
        && paddr == EBT_ADDR_CTRL |-> prdata[31:7] == 25'h0000000) else $error("force bit read set");
    unmapped_err_a: assert property (psel && penable && paddr > EBT_ADDR_AUX |-> pslverr)
        else $error("unmapped access without error");
    ready_high_a: assert property (pready) else $error("ready low");

    // ========================================================
    // pin control
    override_match_a: assert property (compare_pin_override == (ctl[5:4] != 2'b00))
        else $error("override does not follow action field");
    output_enable_a: assert property (compare_output_oe == (compare_pin_override && dir))
        else $error("driver enable wrong");
    stopped_hold_a: assert property (ctl[2:0] == 3'b000 && !$past(wr_ctl)
        |-> $stable(compare_output_pin)) else $error("pin moved while stopped");
    force_set_a: assert property (quiet_force && !pwdata[3] && pwdata[5:4] == 2'b11
        |=> compare_output_pin) else $error("forced set missed");
    force_clear_a: assert property (quiet_force && !pwdata[3] && pwdata[5:4] == 2'b10
        |=> !compare_output_pin) else $error("forced clear missed");
    force_toggle_a: assert property (quiet_force && !pwdata[3] && pwdata[5:4] == 2'b01
        |=> compare_output_pin != $past(compare_output_pin)) else $error("forced toggle missed");
    pwm_force_ignored_a: assert property (quiet_force && pwdata[3]
        |=> $stable(compare_output_pin)) else $error("force honoured in pwm");

    // ========================================================
    // interrupt
    mask_quiet_a: assert property (msk == 2'b00 |-> !irq)
        else $error("interrupt with all masked");
endmodule

bind ebt_timer ebt_timer_properties ebt_timer_properties_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_output_pin(compare_output_pin),
    .compare_output_oe(compare_output_oe), .compare_pin_override(compare_pin_override), .irq(irq));

// *** tb_ebt_timer.sv ***
// self-checking testbench for the eight-bit compare/pwm timer
`timescale 1ns/10ps

module tb_ebt_timer;
    import ebt_pkg::*;

    // ========================================================
    // signals and tables
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, m_lo, m_hi, v;
    logic async_osc_in, ack_overflow, ack_compare, pin, oe, ovr, irq;
    int n_fail = 0;
    int tests_run = 0;
    int i;
    logic [31:0] lo_q[$];
    logic [31:0] hi_q[$];
    // force table: control byte and pin expected after the strobe
    logic [7:0] fc [6] = '{8'hb0, 8'he0, 8'h90, 8'hd0, 8'hf8, 8'hb8};
    logic fp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    // pwm table: control, compare, cycles, accepted high count
    logic [7:0] pc [5] = '{8'h69, 8'h79, 8'h69, 8'h29, 8'h39};
    logic [7:0] pk [5] = '{8'h40, 8'h40, 8'hff, 8'h40, 8'h40};
    int pn [5] = '{256, 256, 256, 510, 510};
    int pl [5] = '{63, 189, 256, 124, 378};
    int ph [5] = '{67, 193, 256, 132, 386};
    int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    ebt_timer ebt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .async_osc_in(async_osc_in), .ack_overflow(ack_overflow),
        .ack_compare(ack_compare), .compare_output_pin(pin), .compare_output_oe(oe),
        .compare_pin_override(ovr), .irq(irq));

    // ========================================================
    // clock and oscillator stand-in (rising edge every six cycles)
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always
    begin
        repeat (3) @(posedge pclk);
        async_osc_in <= ~async_osc_in;
    end

    // ========================================================
    // comparison, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bit1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    // expected read value noted as an accepted range
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        lo_q.push_back(lo);
        hi_q.push_back(hi);
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic measure(input int n, input int lo, input int hi);
        int h;
        h = 0;
        repeat (n)
        begin
            @(posedge pclk);
            #1;
            if (pin === 1'b1)
                h++;
        end
        check({31'h0, h >= lo && h <= hi}, 32'h1);
    endtask

    // read watcher: oldest note against each completed read
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1)
        begin
            m_lo = lo_q.pop_front();
            m_hi = hi_q.pop_front();
            check({31'h0, prdata >= m_lo && prdata <= m_hi}, 32'h1);
        end
    end

    // watchdog, well past the expected run of some 12000 cycles
    initial
    begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        stop_test();
    end

    // ========================================================
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {async_osc_in, ack_overflow, ack_compare} = 3'b000;
        v = $urandom(32'h7438);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 7; i++)
            rd(8'(4 * i), 32'h0, 32'h0);
        v = $urandom_range(255);
        wr(EBT_ADDR_COUNT, v);
        rd(EBT_ADDR_COUNT, v, v);
        v = $urandom_range(255);
        wr(EBT_ADDR_COMPARE, v);
        rd(EBT_ADDR_COMPARE, v, v);
        v = $urandom & 32'h78;
        wr(EBT_ADDR_CTRL, v | 32'h80);
        rd(EBT_ADDR_CTRL, v, v);
        // force strobe in each mode, timer stopped
        wr(EBT_ADDR_AUX, 32'h4);
        wr(EBT_ADDR_COUNT, 32'h33);
        wr(EBT_ADDR_COMPARE, 32'h33);
        for (i = 0; i < 6; i++)
        begin
            wr(EBT_ADDR_CTRL, {24'h0, fc[i]});
            #1 bit1(pin, fp[i]);
        end
        bit1(oe, 1'b1);
        rd(EBT_ADDR_COUNT, 32'h33, 32'h33);
        rd(EBT_ADDR_STATUS, 32'h0, 32'h0);
        wr(EBT_ADDR_CTRL, 32'h0);
        #1 bit1(ovr, 1'b0);
        // overflow moment, masking and vector acknowledge
        wr(EBT_ADDR_COMPARE, 32'h80);
        wr(EBT_ADDR_MASK, 32'h1);
        wr(EBT_ADDR_CTRL, 32'h1);
        wr(EBT_ADDR_COUNT, 32'hfe);
        @(posedge pclk);
        #1 bit1(irq, 1'b0);
        @(posedge pclk);
        #1 bit1(irq, 1'b1);
        wr(EBT_ADDR_CTRL, 32'h0);
        wr(EBT_ADDR_MASK, 32'h0);
        #1 bit1(irq, 1'b0);
        wr(EBT_ADDR_MASK, 32'h1);
        #1 bit1(irq, 1'b1);
        @(posedge pclk);
        ack_overflow <= 1'b1;
        @(posedge pclk);
        ack_overflow <= 1'b0;
        rd(EBT_ADDR_STATUS, 32'h0, 32'h0);
        // a counter write hides a match on the next timer clock only
        wr(EBT_ADDR_MASK, 32'h0);
        wr(EBT_ADDR_COMPARE, 32'h10);
        wr(EBT_ADDR_CTRL, 32'h1);
        wr(EBT_ADDR_COUNT, 32'h10);
        repeat (3) @(posedge pclk);
        rd(EBT_ADDR_STATUS, 32'h0, 32'h0);
        wr(EBT_ADDR_COUNT, 32'h0e);
        repeat (3) @(posedge pclk);
        rd(EBT_ADDR_STATUS, 32'h2, 32'h2);
        wr(EBT_ADDR_STATUS, 32'h2);
        rd(EBT_ADDR_STATUS, 32'h0, 32'h0);
        wr(EBT_ADDR_COUNT, 32'h0e);
        repeat (3) @(posedge pclk);
        ack_compare <= 1'b1;
        @(posedge pclk);
        ack_compare <= 1'b0;
        rd(EBT_ADDR_STATUS, 32'h0, 32'h0);
        // phase pwm flags overflow at bottom, not at the top turn
        wr(EBT_ADDR_MASK, 32'h1);
        wr(EBT_ADDR_CTRL, 32'h9);
        wr(EBT_ADDR_COUNT, 32'h1);
        repeat (400) @(posedge pclk);
        #1 bit1(irq, 1'b0);
        for (i = 0; i < 300 && irq !== 1'b1; i++)
            @(posedge pclk);
        #1 bit1(irq, 1'b1);
        wr(EBT_ADDR_CTRL, 32'h0);
        wr(EBT_ADDR_STATUS, 32'h3);
        wr(EBT_ADDR_MASK, 32'h0);
        // duty per pwm action, compare at top included
        for (i = 0; i < 5; i++)
        begin
            wr(EBT_ADDR_COMPARE, {24'h0, pk[i]});
            wr(EBT_ADDR_CTRL, {24'h0, pc[i]});
            repeat (600) @(posedge pclk);
            measure(pn[i], pl[i], ph[i]);
        end
        // every clock select code after a prescaler reset
        for (i = 0; i < 8; i++)
        begin
            wr(EBT_ADDR_CTRL, 32'h0);
            wr(EBT_ADDR_COUNT, 32'h0);
            wr(EBT_ADDR_AUX, 32'h2);
            wr(EBT_ADDR_CTRL, 32'(i));
            repeat (i == 0 ? 64 : 4 * dv[i]) @(posedge pclk);
            rd(EBT_ADDR_COUNT, i == 0 ? 0 : 3, i == 0 ? 0 : 5);
        end
        // oscillator as source counts its rising edges
        wr(EBT_ADDR_CTRL, 32'h0);
        wr(EBT_ADDR_COUNT, 32'h0);
        wr(EBT_ADDR_AUX, 32'h1);
        wr(EBT_ADDR_CTRL, 32'h1);
        repeat (60) @(posedge pclk);
        rd(EBT_ADDR_COUNT, 32'd9, 32'd11);
        stop_test();
    end
endmodule
